/* File: include/port_power_defs.svh */
// Purpose: Constants for the port power state controller
// Assumes: pclk at 100 MHz
// Notes: Times in microseconds unless named otherwise
`ifndef PORT_POWER_DEFS_SVH
`define PORT_POWER_DEFS_SVH
`define CLK_MHZ 100
`define FAULT_RETRY_WAIT_US 100
`define FAULT_CHECK_TIME_US 10
`define ATTACH_QUAL_TIME_US 100
`define DETACH_QUAL_TIME_US 100
`define VBUS_DISCHARGE_TIME_US 100
`define CDP_ANSWER_MS 20
`define CDP_ANSWER_CYC (`CDP_ANSWER_MS * 1000 * `CLK_MHZ)
`define CDP_RESPONSE_CYC 16
`define US_TO_CYC(t) ((t) * `CLK_MHZ)
`define ERR_BITS 6
`define CTRL_REG_OFFSET 8'h00
`define STATUS_REG_OFFSET 8'h04
`endif

/* File: include/port_power_pkg.sv */
package port_power_pkg;
    typedef enum logic [1:0] {
        power_detect,
        power_active,
        power_error,
        power_discharge
    } power_state_type;
    typedef enum logic [2:0] {
        mode_cycle,
        mode_pass,
        mode_dcp,
        mode_sdp,
        mode_cdp
    } active_mode_type;
    typedef enum logic [1:0] {
        fault_idle,
        fault_wait,
        fault_check
    } fault_phase_type;
    function automatic active_mode_type decode_mode(input logic a, input logic b,
                                                    input logic em);
        active_mode_type m;
        m = mode_cycle;
        unique case ({a, b, em})
            3'b010, 3'b110: m = mode_pass;
            3'b011: m = mode_dcp;
            3'b100: m = mode_sdp;
            3'b111: m = mode_cdp;
            default: m = mode_cycle;
        endcase
        return m;
    endfunction
    function automatic logic is_bc_mode(input active_mode_type m);
        return (m == mode_sdp) || (m == mode_dcp) || (m == mode_cdp);
    endfunction
endpackage

/* File: hw/qual_timer.sv */
// Purpose: Qualifies a level held for a number of cycles
// Assumes: Synchronous inputs
// Notes: Output is a level, high while qualified
`timescale 1ns/100ps
module qual_timer #(
    parameter int CYCLES = 10000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arm,
    input wire logic cond,
    output logic done
);
    logic [31:0] count;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 32'h0;
            done <= 1'b0;
        end else if (!arm || !cond) begin
            count <= 32'h0;
            done <= 1'b0;
        end else if (count >= 32'(CYCLES)) begin
            done <= 1'b1;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule

/* File: hw/port_power_ctrl.sv */
// Purpose: Port power state, fault handling, attach/removal and Active modes
// Assumes: Analog comparisons arrive as synchronous logic levels
// Notes: Registers over APB; long timings are parameters
`timescale 1ns/100ps
`include "port_power_defs.svh"
module port_power_ctrl
    import port_power_pkg::*;
#(
    parameter int RETRY_CYC = `US_TO_CYC(`FAULT_RETRY_WAIT_US),
    parameter int CHECK_CYC = `US_TO_CYC(`FAULT_CHECK_TIME_US),
    parameter int ATTACH_CYC = `US_TO_CYC(`ATTACH_QUAL_TIME_US),
    parameter int DETACH_CYC = `US_TO_CYC(`DETACH_QUAL_TIME_US),
    parameter int DISCHARGE_CYC = `US_TO_CYC(`VBUS_DISCHARGE_TIME_US),
    parameter int CDP_CYC = `CDP_ANSWER_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`ERR_BITS-1:0] error_in,
    input wire logic main_supply_ok,
    input wire logic load_above_attach,
    input wire logic load_below_detach,
    input wire logic vbus_discharged,
    input wire logic dplus_mid_level,
    input wire logic dplus_low,
    input wire logic device_charging,
    output logic port_switch_on,
    output logic bypass_switch_on,
    output logic discharge_on,
    output logic hs_switch_closed,
    output logic const_current_limit,
    output logic dcp_short_on,
    output logic cdp_profile_on,
    output logic dminus_out_pin,
    output logic emulation_cycle_run,
    output logic attach_n_o,
    output logic attach_n_oe_n,
    output logic fault_alert_n_o,
    output logic fault_alert_n_oe_n
);
    localparam logic [7:0] REG_CTRL = `CTRL_REG_OFFSET;
    localparam logic [7:0] REG_STATUS = `STATUS_REG_OFFSET;
    power_state_type state;
    fault_phase_type fault_phase;
    active_mode_type mode;
    active_mode_type cur_mode;
    logic port_power_enable;
    logic fault_hold;
    logic detect_enable_ctrl;
    logic mode_sel_a;
    logic mode_sel_b;
    logic emulation_enable;
    logic fault_flag;
    logic attach_status;
    logic attach_pin_status;
    logic detach_status;
    logic enable_prev;
    logic attached;
    logic host_check;
    logic fault_clear_wr;
    logic status_clear_wr;
    logic any_error;
    logic attach_qual;
    logic detach_qual;
    logic [31:0] fault_count;
    logic [31:0] dis_count;
    logic [31:0] cdp_count;
    logic renegotiate;
    logic wr_access;
    assign any_error = |error_in;
    assign mode = decode_mode(mode_sel_a, mode_sel_b, emulation_enable);
    assign wr_access = psel && penable && pwrite;
    assign fault_clear_wr = wr_access && paddr == REG_STATUS && pwdata[0];
    assign status_clear_wr = wr_access && paddr == REG_STATUS;
    // Falling enable or flag clear asks for one check
    assign host_check = (enable_prev && !port_power_enable) || fault_clear_wr;
    assign renegotiate = state == power_active && is_bc_mode(mode) && is_bc_mode(cur_mode)
        && mode != cur_mode;
    qual_timer #(.CYCLES(ATTACH_CYC)) attach_timer (
        .pclk(pclk),
        .presetn(presetn),
        .arm(state == power_detect && !attached),
        .cond(load_above_attach),
        .done(attach_qual)
    );
    qual_timer #(.CYCLES(DETACH_CYC)) detach_timer (
        .pclk(pclk),
        .presetn(presetn),
        .arm(detect_enable_ctrl && attached &&
             (state == power_detect || state == power_active)),
        .cond(load_below_detach),
        .done(detach_qual)
    );
    // APB slave, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_power_enable <= 1'b0;
            fault_hold <= 1'b0;
            detect_enable_ctrl <= 1'b1;
            mode_sel_a <= 1'b0;
            mode_sel_b <= 1'b1;
            emulation_enable <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != REG_CTRL && paddr != REG_STATUS;
            if (wr_access && paddr == REG_CTRL) begin
                port_power_enable <= pwdata[0];
                fault_hold <= pwdata[1];
                detect_enable_ctrl <= pwdata[2];
                mode_sel_a <= pwdata[3];
                mode_sel_b <= pwdata[4];
                emulation_enable <= pwdata[5];
            end
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    REG_CTRL: prdata <= {26'h0, emulation_enable, mode_sel_b, mode_sel_a,
                                         detect_enable_ctrl, fault_hold, port_power_enable};
                    REG_STATUS: prdata <= {24'h0, cur_mode, state == power_active,
                                           detach_status, attach_status, attach_pin_status,
                                           fault_flag} ;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
    // Status bits; hardware set beats software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attach_status <= 1'b0;
            attach_pin_status <= 1'b0;
            detach_status <= 1'b0;
            attached <= 1'b0;
            enable_prev <= 1'b0;
        end else begin
            enable_prev <= port_power_enable;
            if (status_clear_wr && pwdata[2])
                attach_status <= 1'b0;
            if (status_clear_wr && pwdata[3])
                detach_status <= 1'b0;
            if (attach_qual && !attached) begin
                attached <= 1'b1;
                attach_status <= 1'b1;
                attach_pin_status <= 1'b1;
            end
            if (detach_qual) begin
                attached <= 1'b0;
                attach_pin_status <= 1'b0;
                detach_status <= 1'b1;
            end
        end
    end
    // Power state and fault handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= power_detect;
            fault_phase <= fault_idle;
            fault_flag <= 1'b0;
            fault_count <= 32'h0;
            dis_count <= 32'h0;
            cur_mode <= mode_pass;
        end else begin
            if (fault_clear_wr)
                fault_flag <= 1'b0;
            unique case (state)
                power_detect: begin
                    if (any_error) begin
                        state <= power_error;
                        fault_flag <= 1'b1;
                        fault_phase <= fault_hold ? fault_idle : fault_wait;
                        fault_count <= 32'h0;
                    end else if (attached && port_power_enable && main_supply_ok) begin
                        state <= power_active;
                        cur_mode <= mode;
                        dis_count <= 32'h0;
                        if (is_bc_mode(mode))
                            state <= power_discharge;
                    end
                end
                power_active: begin
                    if (any_error) begin
                        state <= power_error;
                        fault_flag <= 1'b1;
                        fault_phase <= fault_hold ? fault_idle : fault_wait;
                        fault_count <= 32'h0;
                    end else if (detach_qual) begin
                        state <= power_discharge;
                        dis_count <= 32'h0;
                    end else if (mode != cur_mode && is_bc_mode(mode)) begin
                        // Any entry into a BC mode cycles VBUS, not only BC to BC
                        state <= power_discharge;
                        cur_mode <= mode;
                        dis_count <= 32'h0;
                    end else if (mode != cur_mode) begin
                        cur_mode <= mode;
                    end
                end
                power_discharge: begin
                    dis_count <= dis_count + 32'h1;
                    if (vbus_discharged || dis_count >= 32'(DISCHARGE_CYC))
                        state <= attached ? power_active : power_detect;
                end
                power_error: begin
                    unique case (fault_phase)
                        fault_wait: begin
                            fault_count <= fault_count + 32'h1;
                            if (fault_count >= 32'(RETRY_CYC)) begin
                                fault_phase <= fault_check;
                                fault_count <= 32'h0;
                            end
                        end
                        fault_check: begin
                            fault_count <= fault_count + 32'h1;
                            if (any_error) begin
                                fault_phase <= fault_wait;
                                fault_count <= 32'h0;
                            end else if (fault_count >= 32'(CHECK_CYC)) begin
                                state <= power_active;
                                fault_phase <= fault_idle;
                                fault_flag <= 1'b0;
                            end
                        end
                        default: begin
                            // One check per host command
                            if (host_check && !any_error) begin
                                state <= power_active;
                                fault_flag <= 1'b0;
                            end
                        end
                    endcase
                end
            endcase
        end
    end
    // CDP D- answer timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdp_count <= 32'h0;
            dminus_out_pin <= 1'b0;
        end else if (!(state == power_active && cur_mode == mode_cdp)) begin
            cdp_count <= 32'h0;
            dminus_out_pin <= 1'b0;
        end else if (dminus_out_pin ? dplus_low : dplus_mid_level) begin
            cdp_count <= cdp_count + 32'h1;
            if (cdp_count >= 32'(`CDP_RESPONSE_CYC) || cdp_count >= 32'(CDP_CYC - 1)) begin
                dminus_out_pin <= !dminus_out_pin;
                cdp_count <= 32'h0;
            end
        end else begin
            cdp_count <= 32'h0;
        end
    end
    // Switch and pin outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_switch_on <= 1'b0;
            bypass_switch_on <= 1'b0;
            discharge_on <= 1'b0;
            hs_switch_closed <= 1'b0;
            const_current_limit <= 1'b0;
            dcp_short_on <= 1'b0;
            cdp_profile_on <= 1'b0;
            emulation_cycle_run <= 1'b0;
            attach_n_o <= 1'b0;
            attach_n_oe_n <= 1'b1;
            fault_alert_n_o <= 1'b0;
            fault_alert_n_oe_n <= 1'b1;
        end else begin
            // Mutually exclusive by construction
            // Opens together with the attach pin release on removal
            port_switch_on <= state == power_active && !detach_qual;
            bypass_switch_on <= state == power_detect && !any_error;
            discharge_on <= state == power_discharge;
            hs_switch_closed <= state == power_active && (cur_mode == mode_pass ||
                cur_mode == mode_sdp || cur_mode == mode_cdp);
            const_current_limit <= state == power_active &&
                (cur_mode == mode_cdp || (cur_mode == mode_dcp && device_charging));
            dcp_short_on <= state == power_active && cur_mode == mode_dcp;
            cdp_profile_on <= state == power_active && cur_mode == mode_cdp;
            emulation_cycle_run <= state == power_active && cur_mode == mode_cycle;
            attach_n_oe_n <= !(attached && !detach_qual);
            fault_alert_n_oe_n <= !(fault_flag || state == power_error);
        end
    end
    property p_attach_pin;
        @(posedge pclk) disable iff (!presetn)
        $rose(attached) |=> !attach_n_oe_n;
    endproperty
    a_attach_pin: assert property (p_attach_pin)
        else $error("attach pin not driven after attach");
    property p_switch_excl;
        @(posedge pclk) disable iff (!presetn)
        !(port_switch_on && bypass_switch_on);
    endproperty
    a_switch_excl: assert property (p_switch_excl)
        else $error("both switches closed");
    property p_err_entry;
        @(posedge pclk) disable iff (!presetn)
        (state == power_active && any_error) |=> state == power_error
        ##1 !fault_alert_n_oe_n;
    endproperty
    a_err_entry: assert property (p_err_entry)
        else $error("error not entered");
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (state == power_error && fault_phase == fault_idle && !host_check)
        |=> state == power_error;
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched error left without command");
    property p_hs_detect;
        @(posedge pclk) disable iff (!presetn)
        (state == power_detect) [*2] |-> !hs_switch_closed;
    endproperty
    a_hs_detect: assert property (p_hs_detect)
        else $error("hs switch closed in detect");
    // Error and removal take priority over a mode change
    property p_reneg;
        @(posedge pclk) disable iff (!presetn)
        (renegotiate && !any_error && !detach_qual) |=> state == power_discharge;
    endproperty
    a_reneg: assert property (p_reneg)
        else $error("no vbus cycle on mode change");
    property p_cdp_cc;
        @(posedge pclk) disable iff (!presetn)
        (state == power_active && cur_mode == mode_cdp) [*2] |-> const_current_limit;
    endproperty
    a_cdp_cc: assert property (p_cdp_cc)
        else $error("cdp without constant current");
    property p_removal;
        @(posedge pclk) disable iff (!presetn)
        (state == power_active && detach_qual && !any_error) |=> state == power_discharge
        ##1 !port_switch_on && !bypass_switch_on;
    endproperty
    a_removal: assert property (p_removal)
        else $error("removal not handled");
    c_attach: cover property (@(posedge pclk) disable iff (!presetn) $rose(attached));
    c_recover: cover property (@(posedge pclk) disable iff (!presetn)
        state == power_error ##1 state == power_active);
    c_cdp: cover property (@(posedge pclk) disable iff (!presetn) $rose(dminus_out_pin));
endmodule

/* File: tb/portable_device_model.sv */
// Purpose: Attached portable device as seen from the port pins
// Assumes: Levels change just after pclk edges
// Notes: LAG sets how slowly VBUS reads back as discharged
`timescale 1ns/100ps
module portable_device_model #(
    parameter int LAG = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic plugged,
    input wire logic charge_req,
    input wire logic cdp_probe,
    input wire logic port_switch_on,
    input wire logic bypass_switch_on,
    input wire logic discharge_on,
    output logic load_above_attach,
    output logic load_below_detach,
    output logic vbus_discharged,
    output logic dplus_mid_level,
    output logic dplus_low,
    output logic device_charging
);
    int lag_count;
    wire logic fed = plugged & (port_switch_on | bypass_switch_on);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_above_attach <= 1'b0;
            load_below_detach <= 1'b1;
            device_charging <= 1'b0;
            dplus_mid_level <= 1'b0;
            dplus_low <= 1'b1;
        end else begin
            // No load without a switch feeding VBUS
            load_above_attach <= fed;
            load_below_detach <= !fed;
            device_charging <= charge_req & port_switch_on;
            dplus_mid_level <= cdp_probe & port_switch_on;
            dplus_low <= !(cdp_probe & port_switch_on);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag_count <= 0;
            vbus_discharged <= 1'b0;
        end else begin
            // Slow decay so the design cannot rely on an instant drop
            lag_count <= discharge_on ? lag_count + 1 : 0;
            vbus_discharged <= discharge_on && lag_count >= LAG;
        end
    end
endmodule

/* File: tb/usb_port_power_state_control_tb_top.sv */
// Purpose: Self-checking bench for the port power controller
// Assumes: Shortened timing parameters, bench acts as APB master
// Notes: Mode flags come from a small integer model
`timescale 1ns/100ps
`define CHK(what, e, g) check_val(what, 32'(e), 32'(g))
module usb_port_power_state_control_tb_top;
    localparam int QC = 20;
    localparam int DC = 40;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [5:0] error_in = 6'h00;
    logic main_supply_ok = 0, plugged = 0, charge_req = 0, cdp_probe = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, load_above_attach, load_below_detach, vbus_discharged;
    wire logic dplus_mid_level, dplus_low, device_charging;
    wire logic [12:0] obs;
    int bad_count = 0, num_checks = 0, cycles = 0, code, flags, mk, got, m;
    int mode_seq[7] = '{4, 7, 3, 1, 5, 6, 2};
    port_power_ctrl #(.RETRY_CYC(QC), .CHECK_CYC(QC), .ATTACH_CYC(QC), .DETACH_CYC(DC),
        .DISCHARGE_CYC(QC), .CDP_CYC(QC)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .error_in(error_in),
        .main_supply_ok(main_supply_ok), .load_above_attach(load_above_attach),
        .load_below_detach(load_below_detach), .vbus_discharged(vbus_discharged),
        .dplus_mid_level(dplus_mid_level), .dplus_low(dplus_low),
        .device_charging(device_charging), .port_switch_on(obs[0]),
        .bypass_switch_on(obs[1]), .discharge_on(obs[2]), .hs_switch_closed(obs[3]),
        .const_current_limit(obs[4]), .dcp_short_on(obs[5]), .cdp_profile_on(obs[6]),
        .dminus_out_pin(obs[7]), .emulation_cycle_run(obs[8]), .attach_n_o(obs[11]),
        .attach_n_oe_n(obs[9]), .fault_alert_n_o(obs[12]), .fault_alert_n_oe_n(obs[10]));
    portable_device_model partner_u (.pclk(pclk), .presetn(presetn), .plugged(plugged),
        .charge_req(charge_req), .cdp_probe(cdp_probe), .port_switch_on(obs[0]),
        .bypass_switch_on(obs[1]), .discharge_on(obs[2]),
        .load_above_attach(load_above_attach), .load_below_detach(load_below_detach),
        .vbus_discharged(vbus_discharged), .dplus_mid_level(dplus_mid_level),
        .dplus_low(dplus_low), .device_charging(device_charging));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            `CHK("pready", 1, 0);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_obs(input int i, input logic v, input int lim, input string what);
        int n;
        for (n = 0; n < lim && obs[i] !== v; n++)
            @(posedge pclk);
        `CHK(what, v, obs[i]);
    endtask
    // Bits: 0 hs, 1 const limit, 2 cdp, 3 dcp, 4 cycle, 5 discharge on entry
    function automatic int exp_flags(input int c);
        case (c)
            2, 6: return 1;
            4: return 33;
            7: return 39;
            3: return 42;
            default: return 16;
        endcase
    endfunction
    always @(posedge pclk) begin
        cycles++;
        if (obs[0] === 1'b1 && obs[1] === 1'b1)
            `CHK("both switches", 0, 1);
        if (cycles >= 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        m = $urandom(44085);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0);
        `CHK("ctrl reset", 32'h14, rd);
        apb(0, 8'h40, 0);
        `CHK("unmapped", 32'h8000_0000, {perr, rd[30:0]});
        `CHK("detect switches", 4'b0010, obs[3:0]);
        `CHK("open drain levels", 0, obs[12:11]);
        plugged <= 1'b1;
        repeat (QC / 2) @(posedge pclk);
        `CHK("early attach", 1, obs[9]);
        wait_obs(9, 0, QC + 10, "attach pin");
        apb(0, 8'h04, 0);
        `CHK("attach status", 2'b11, rd[2:1]);
        apb(1, 8'h00, 32'h15);
        repeat (10) @(posedge pclk);
        `CHK("no supply", 0, obs[0]);
        main_supply_ok <= 1'b1;
        charge_req <= 1'b1;
        wait_obs(0, 1, 20, "port on");
        `CHK("bypass off", 0, obs[1]);
        foreach (mode_seq[k]) begin
            code = mode_seq[k];
            flags = exp_flags(code);
            mk = (code % 4 == 1) ? 16 : 31;
            apb(1, 8'h00, {26'h0, code[0], code[1], code[2], 3'h5});
            if (flags[5]) begin
                wait_obs(2, 1, 20, "entry discharge");
                `CHK("vbus off", 0, obs[0]);
            end
            wait_obs(mk == 31 ? 0 : 8, 1, QC + 20, "mode ready");
            repeat (3) @(posedge pclk);
            got = {obs[8], obs[5], obs[6], obs[4], obs[3]};
            `CHK("mode flags", flags & mk, got & mk);
            if (code == 7) begin
                cdp_probe <= 1'b1;
                wait_obs(7, 1, QC + 20, "dminus drive");
                cdp_probe <= 1'b0;
                wait_obs(7, 0, QC + 20, "dminus release");
            end
        end
        apb(1, 8'h00, 32'h11);
        error_in <= 6'(1 << ($urandom % 6));
        wait_obs(10, 0, 3, "alert");
        wait_obs(0, 0, 3, "error opens port");
        error_in <= 6'h00;
        repeat (10) @(posedge pclk);
        `CHK("retry wait", 0, obs[10]);
        wait_obs(10, 1, 3 * QC + 20, "alert release");
        wait_obs(0, 1, 20, "recovered");
        apb(1, 8'h00, 32'h13);
        error_in <= 6'(1 << ($urandom % 6));
        wait_obs(10, 0, 3, "latched alert");
        repeat (3 * QC) @(posedge pclk);
        apb(0, 8'h04, 0);
        `CHK("fault flag", 1, rd[0]);
        apb(1, 8'h04, 32'h1);
        repeat (10) @(posedge pclk);
        `CHK("error persists", 0, obs[10]);
        error_in <= 6'h00;
        repeat (3 * QC) @(posedge pclk);
        `CHK("no self recovery", 0, obs[10]);
        apb(1, 8'h04, 32'h1);
        wait_obs(10, 1, 20, "check release");
        wait_obs(0, 1, 20, "latched recovery");
        apb(1, 8'h00, 32'h15);
        plugged <= 1'b0;
        wait_obs(9, 1, DC + 20, "attach release");
        `CHK("switches open", 0, obs[1:0]);
        wait_obs(2, 1, 10, "removal discharge");
        wait_obs(1, 1, DC + 40, "back to detect");
        `CHK("port stays off", 0, obs[0]);
        apb(0, 8'h04, 0);
        `CHK("detach flags", 2'b10, {rd[3], rd[1]});
        complete_run();
    end
endmodule
